// ### rtl/dct_pkg.sv
// Package for the DDR2 command timing keeper: constants, command codes, carriers.
// Assumes one 10 MHz clock; cycle counts derive from ps figures by round-up.
package dct_pkg;

  // Clock period in picoseconds
  localparam int unsigned CLK_PERIOD_PS = 100000;

  // Round a time in ps up to whole clock edges, never below one cycle
  function automatic int unsigned ps_to_cycles(input int unsigned t_ps);
    int unsigned n;
    n = (t_ps + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    return (n == 0) ? 1 : n;
  endfunction

  // Timing figures as printed, in their own units, and the precharge cycle count derived from them
  localparam int unsigned WRITE_TO_READ_DELAY_NCK    = 2;
  localparam int unsigned CLOCK_ENABLE_MIN_PULSE_NCK = 3;
  localparam int unsigned POWERDOWN_EXIT_SPACING_NCK = 2;
  localparam int unsigned PRECHARGE_TIME_PS          = 15000;
  localparam int unsigned PRECHARGE_CYCLE_COUNT      = ps_to_cycles(PRECHARGE_TIME_PS);

  // Counter width, mode register layout and synchroniser depth
  localparam int unsigned CNT_W        = 8;
  localparam int unsigned MR_W         = 14;
  localparam int unsigned MR_STROBE_B  = 10;
  localparam int unsigned MR_WR_LSB    = 9;
  localparam int unsigned MR_WR_W      = 3;
  localparam int unsigned PIPE_DEPTH   = 3;

  // Decoded command at the pins
  typedef enum logic [2:0] {
    DCT_NOP, DCT_ACTIVATE, DCT_READ, DCT_WRITE, DCT_WRITE_AP,
    DCT_PRECHARGE, DCT_MODE_SET
  } dct_cmd_e;

  // Command with its address field
  typedef struct packed {
    dct_cmd_e          cmd;
    logic [MR_W-1:0]   addr;
  } dct_req_s;

  // Status reported to the core
  typedef struct packed {
    logic cke_level;
    logic single_strobe;
    logic read_ok;
    logic act_ok;
    logic recovering;
  } dct_stat_s;

endpackage

// ### rtl/dct_cnt.sv
// Down-counter used for each cycle-count spacing window.
// Assumes load and count come from logic on the same clock.
`timescale 1ns/1ns
module dct_cnt #(
  parameter int unsigned W = 8
) (
  // Clock and reset
  input  wire logic         core_clk,
  input  wire logic         reset,
  // Control
  input  wire logic         load,
  input  wire logic [W-1:0] value,
  // State
  output logic              busy
);
  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;

  // Load wins over count; stops at zero
  always_comb begin
    cnt_d = cnt_q;
    if (load) begin
      cnt_d = value;
    end else if (cnt_q != '0) begin
      cnt_d = cnt_q - W'(1);
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  assign busy = (cnt_q != '0);
endmodule

// ### rtl/dct_timing.sv
// Behaviour
// - New clock-enable level taken only after four equal consecutive samples.
// - Mode bit 10 zero gives differential strobe, one gives single-ended.
// - Picosecond times become clock counts by dividing and rounding up.
// - Auto-precharge write recovery is programmed write recovery plus precharge count.
// - Counts use real clock edges; activate allowed at power-down exit plus two.
//
// Device-side timing keeper for a DDR2 command interface: filters clock
// enable, holds the mode bits and reports when reads and activates are legal.
// Assumes commands arrive already decoded on core_clk; clock enable is a pin.
`timescale 1ns/1ns
module dct_timing
  import dct_pkg::*;
#(
  parameter int unsigned CNT_WIDTH = dct_pkg::CNT_W
) (
  // Clock and reset
  input  wire logic              core_clk,
  input  wire logic              reset,
  // Pins
  input  wire logic              cke_pin,
  // Decoded commands
  input  wire dct_pkg::dct_req_s req,
  input  wire logic              last_wdata,
  // Status
  output dct_pkg::dct_stat_s     stat,
  output logic [CNT_WIDTH-1:0]   ap_recovery
);
  import dct_pkg::*;

  // Pin sync and filter state
  logic [PIPE_DEPTH-1:0] cke_sync_q;
  logic [PIPE_DEPTH-1:0] cke_sync_d;
  logic [1:0]            cke_run_q;
  logic [1:0]            cke_run_d;
  logic                  cke_lvl_q;
  logic                  cke_lvl_d;
  logic                  cke_prev_q;
  logic                  cke_prev_d;
  // Mode state and outputs
  logic                  single_q;
  logic                  single_d;
  logic [MR_WR_W-1:0]    wr_q;
  logic [MR_WR_W-1:0]    wr_d;
  dct_stat_s             stat_q;
  dct_stat_s             stat_d;
  logic [CNT_WIDTH-1:0]  ap_q;
  logic [CNT_WIDTH-1:0]  ap_d;
  logic                  wtr_busy;
  logic                  xp_busy;
  logic                  dal_busy;
  logic                  pd_exit;

  // Three-flop pin synchroniser; stage 0 only feeds stage 1
  always_comb begin
    cke_sync_d = {cke_sync_q[PIPE_DEPTH-2:0], cke_pin};
  end

  // four equal samples
  // Count runs of the settled sample; the level moves only after three edges
  always_comb begin
    cke_run_d = cke_run_q;
    cke_lvl_d = cke_lvl_q;
    if (cke_sync_q[1] != cke_sync_q[2] || cke_sync_q[2] == cke_lvl_q) begin
      cke_run_d = '0;
    end else if (cke_run_q == 2'(CLOCK_ENABLE_MIN_PULSE_NCK - 1)) begin
      cke_run_d = '0;
      cke_lvl_d = cke_sync_q[2];
    end else begin
      cke_run_d = cke_run_q + 2'(1);
    end
    cke_prev_d = cke_lvl_q;
  end

  assign pd_exit = cke_lvl_q & ~cke_prev_q;

  always_ff @(posedge core_clk) begin
    if (reset) begin
      cke_sync_q <= '0;
      cke_run_q  <= '0;
      cke_lvl_q  <= 1'b0;
      cke_prev_q <= 1'b0;
    end else begin
      cke_sync_q <= cke_sync_d;
      cke_run_q  <= cke_run_d;
      cke_lvl_q  <= cke_lvl_d;
      cke_prev_q <= cke_prev_d;
    end
  end

  // strobe style from mode bit
  // Mode set captures strobe style and write recovery field
  always_comb begin
    single_d = single_q;
    wr_d     = wr_q;
    if (req.cmd == DCT_MODE_SET) begin
      single_d = req.addr[MR_STROBE_B];
      wr_d     = req.addr[MR_WR_LSB +: MR_WR_W];
    end
  end

  // recovery sum
  // Write recovery is coded as value minus one in the field
  always_comb begin
    ap_d = CNT_WIDTH'(wr_q) + CNT_WIDTH'(1) + CNT_WIDTH'(PRECHARGE_CYCLE_COUNT);
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      single_q <= 1'b0;
      wr_q     <= '0;
      ap_q     <= '0;
    end else begin
      single_q <= single_d;
      wr_q     <= wr_d;
      ap_q     <= ap_d;
    end
  end

  dct_cnt #(.W(CNT_WIDTH)) u_wtr (
    .core_clk (core_clk),
    .reset    (reset),
    .load     (last_wdata),
    .value    (CNT_WIDTH'(WRITE_TO_READ_DELAY_NCK)),
    .busy     (wtr_busy)
  );

  dct_cnt #(.W(CNT_WIDTH)) u_xp (
    .core_clk (core_clk),
    .reset    (reset),
    .load     (pd_exit),
    .value    (CNT_WIDTH'(POWERDOWN_EXIT_SPACING_NCK - 1)),
    .busy     (xp_busy)
  );

  dct_cnt #(.W(CNT_WIDTH)) u_dal (
    .core_clk (core_clk),
    .reset    (reset),
    .load     (req.cmd == DCT_WRITE_AP),
    .value    (ap_q),
    .busy     (dal_busy)
  );

  // Registered status; read and activate gated by their windows
  always_comb begin
    stat_d.cke_level     = cke_lvl_d;
    stat_d.single_strobe = single_d;
    stat_d.read_ok       = ~wtr_busy & ~last_wdata;
    stat_d.act_ok        = ~xp_busy & ~pd_exit & ~dal_busy & cke_lvl_q;
    stat_d.recovering    = dal_busy;
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      stat_q <= '0;
    end else begin
      stat_q <= stat_d;
    end
  end

  assign stat        = stat_q;
  assign ap_recovery = ap_q;
endmodule

// ### bench/dct_timing_assertions.sv
// Checker for the timing keeper status outputs.
// Assumes it is bound into dct_timing.
`timescale 1ns/1ns
module dct_chk
  import dct_pkg::*;
#(parameter int unsigned CNT_WIDTH = 8) (
  // Watched ports
  input wire logic                 core_clk,
  input wire logic                 reset,
  input wire logic                 cke_pin,
  input wire dct_pkg::dct_req_s    req,
  input wire logic                 last_wdata,
  input wire dct_pkg::dct_stat_s   stat,
  input wire logic [CNT_WIDTH-1:0] ap_recovery
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  // Mode word gives strobe style and recovery sum
  a_strobe_mode: assert property (req.cmd == DCT_MODE_SET |=>
    stat.single_strobe == $past(req.addr[MR_STROBE_B])) else $error("strobe style wrong");
  // Recovery sum sits one stage behind the captured field, so look two edges on
  a_recovery_sum: assert property (req.cmd == DCT_MODE_SET |-> ##2
    ap_recovery == $past(req.addr[MR_WR_LSB+:MR_WR_W], 2) + 1 + PRECHARGE_CYCLE_COUNT)
    else $error("recovery sum wrong");
  // Short pin dips must not reach the level
  // Pin samples that moved the level lie three to six edges back
  a_cke_three: assert property ($changed(stat.cke_level) |->
    $past(cke_pin, 4) == stat.cke_level && $past(cke_pin, 5) == stat.cke_level &&
    $past(cke_pin, 6) == stat.cke_level) else $error("enable filter wrong");
  a_exit_gap: assert property ($rose(stat.cke_level) && !stat.recovering |->
    !stat.act_ok ##[1:4] stat.act_ok) else $error("activate spacing wrong");
  a_read_gap: assert property (last_wdata |=> !stat.read_ok [*2])
    else $error("read allowed too soon");
endmodule

bind dct_timing dct_chk #(.CNT_WIDTH(CNT_WIDTH)) u_chk (.core_clk(core_clk),
  .reset(reset), .cke_pin(cke_pin), .req(req), .last_wdata(last_wdata),
  .stat(stat), .ap_recovery(ap_recovery));

// ### bench/dct_ctl_model.sv
// Controller model: clock enable, commands and last-write marks.
// Assumes the bench calls its tasks; changes land just after an edge.
`timescale 1ns/1ns
module dct_ctl_model
  import dct_pkg::*;
(
  input  wire logic         core_clk,
  output dct_pkg::dct_req_s req,
  output logic              cke_pin,
  output logic              last_wdata
);
  int gap_q = 0;
  // write data always clean and clock never changed, so no rewrite
  // Quiet bus at start
  initial begin
    req = '{DCT_NOP, 14'h0000};
    cke_pin = 1'b0;
    last_wdata = 1'b0;
  end
  always @(posedge core_clk)
    if (gap_q != 0) gap_q <= gap_q - 1;
  task automatic cke_set(input logic v, input int n);
    @(posedge core_clk);
    cke_pin <= v;
    repeat (n - 1) @(posedge core_clk);
  endtask
  task automatic cmd(input dct_cmd_e c, input logic [MR_W-1:0] a);
    while (c == DCT_READ && gap_q != 0) @(posedge core_clk);
    @(posedge core_clk);
    req <= '{c, a};
    @(posedge core_clk);
    req <= '{DCT_NOP, ~a}; // Stale address never lingers
  endtask
  // Mark the last write beat
  task automatic wdata_end();
    @(posedge core_clk);
    last_wdata <= 1'b1;
    @(posedge core_clk);
    last_wdata <= 1'b0;
    gap_q <= 2;
  endtask
endmodule

// ### bench/test_dct_timing.sv
// Bench for the timing keeper; notes are compared as results show.
// Assumes package, design and model compile first.
`timescale 1ns/1ns
module test_dct_timing;
  import dct_pkg::*;
  logic             core_clk = 1'b0;
  logic             reset = 1'b1;
  logic             look = 1'b0;
  logic             cke_pin;
  logic             last_wdata;
  dct_req_s         req;
  dct_stat_s        stat;
  logic [CNT_W-1:0] ap_recovery;
  logic [15:0]      lfsr_q = 16'hBABD;
  logic [13:0]      a;
  logic [11:0]      n;
  logic [11:0]      notes[$];
  int               failures = 0;
  int               checks_done = 0;
  int               cycles = 0;

  // 100 ns clock
  always #50 core_clk = ~core_clk;

  dct_timing u_dut (.core_clk(core_clk), .reset(reset), .cke_pin(cke_pin),
    .req(req), .last_wdata(last_wdata), .stat(stat), .ap_recovery(ap_recovery));
  dct_ctl_model u_ctl (.core_clk(core_clk), .req(req), .cke_pin(cke_pin),
    .last_wdata(last_wdata));

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic conclude();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Results show for k edges
  task automatic show(input int k);
    look <= 1'b1;
    repeat (k) @(posedge core_clk);
    look <= 1'b0;
  endtask

  // Oldest note meets its field; hang limit too
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 3000) begin
      failures++;
      conclude();
    end
    if (look) begin
      n = notes.pop_front();
      case (n[11:8])
        4'h0: chk(ap_recovery, n[7:0]);
        4'h1: chk(8'(stat.single_strobe), n[7:0]);
        4'h2: chk(8'(stat.cke_level), n[7:0]);
        4'h4: chk(8'(stat.act_ok), n[7:0]);
        4'h5: chk(8'(stat.recovering), n[7:0]);
        default: chk(8'(stat.read_ok), n[7:0]);
      endcase
    end
  end

  // Wake, two-cycle dip, sleep, wake; mode words; write gap
  initial begin
    repeat (2) @(posedge core_clk);
    reset <= 1'b0;
    u_ctl.cke_set(1'b1, 10);
    notes.push_back(10'h201);
    show(1);
    u_ctl.cke_set(1'b0, 1);
    notes.push_back(10'h201);
    show(1);
    u_ctl.cke_set(1'b1, 8);
    u_ctl.cke_set(1'b0, 10);
    notes.push_back(10'h200);
    show(1);
    u_ctl.cke_set(1'b1, 10);
    repeat (8) begin
      lfsr_q = lfsr(lfsr_q);
      a = lfsr_q[13:0];
      u_ctl.cmd(DCT_MODE_SET, a);
      notes.push_back({4'h1, 7'h00, a[10]});
      notes.push_back({4'h0, 8'(a[11:9]) + 8'h01 + 8'(PRECHARGE_CYCLE_COUNT)});
      show(2);
    end
    u_ctl.cmd(DCT_WRITE, 14'h0000);
    u_ctl.wdata_end();
    notes.push_back(10'h300);
    notes.push_back(10'h300);
    show(2);
    u_ctl.cmd(DCT_READ, 14'h0040);
    u_ctl.cmd(DCT_WRITE_AP, 14'h0400);
    @(posedge core_clk);
    notes.push_back(12'h400);
    notes.push_back(12'h501);
    show(2);
    // Longest recovery is nine cycles; then activate and read are open
    repeat (10) @(posedge core_clk);
    notes.push_back(12'h401);
    notes.push_back(12'h301);
    show(2);
    @(posedge core_clk);
    conclude();
  end
endmodule
